// File: logic/ffc_cache.sv
// Purpose: read-only cache between processor reads and a flash word stream
// Assumes: flash answers each section request with its words in order
// Notes: writes are refused; one access may queue behind a running fill
`timescale 1ns/1ps
// Overview of operation
// - read-only cache over 32 MB flash
// - 32KB, four ways, 512-byte lines
// - lines split into 64-byte sections
// - fill starts at the target section
// - target word forwarded as it arrives
// - new flash-needing access aborts the fill
// - abort only at a section boundary
// - evict only when no empty way
// - prefer evicting the least used line
// - eviction ages use counts of the set
// - hit moves line to most recent
// - 1-bit use count, 2-bit recency
// - valid data served without flash
// - allocated line, missing section: fill it
// - miss allocates a line and fills
// - writes are never accepted
// - full-line mode: in order, no abort
module ffc_cache (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_full_line,
  input wire logic i_cpu_req,
  input wire logic i_cpu_write,
  input wire logic [ffc_pkg::ADDR_W-1:0] i_cpu_addr,
  output logic o_cpu_ready,
  output logic o_cpu_ack,
  output logic [ffc_pkg::DATA_W-1:0] o_cpu_rdata,
  output logic o_cpu_wr_err,
  output logic o_fl_req,
  output logic [ffc_pkg::ADDR_W-1:0] o_fl_addr,
  input wire logic i_fl_valid,
  input wire logic [ffc_pkg::DATA_W-1:0] i_fl_data
);
  import ffc_pkg::*;

  // =====================================================================
  // storage
  logic [DATA_W-1:0] mem [MEM_WORDS];
  logic [TAG_W-1:0] tag_r [SETS][WAYS];
  logic [SECTS-1:0] secv_r [SETS][WAYS];
  logic [WAYS-1:0] alloc_r [SETS];
  logic [WAYS-1:0] lfu_r [SETS];
  logic [WAYS*LRU_W-1:0] lru_r [SETS];

  ffc_state_type state_r;
  logic [ADDR_W-1:0] cur_addr_r;
  logic [ADDR_W-1:0] pend_addr_r;
  logic pend_v_r;
  logic fwd_pend_r;
  logic [WAY_W-1:0] way_r;
  logic [SEC_W-1:0] start_sec_r;
  logic [SEC_W-1:0] cur_sec_r;
  logic [WORD_W-1:0] word_cnt_r;

  function automatic logic [MEM_W-1:0] mem_idx(input logic [ADDR_W-1:0] a,
                                               input logic [WAY_W-1:0] w);
    mem_idx = {a[SET_LSB +: SET_W], w, a[SEC_LSB +: SEC_W], a[WORD_LSB +: WORD_W]};
  endfunction

  function automatic logic [WAYS*LRU_W-1:0] lru_touch(input logic [WAYS*LRU_W-1:0] l,
                                                      input logic [WAY_W-1:0] w);
    logic [LRU_W-1:0] lw;
    lw = l[w*LRU_W +: LRU_W];
    lru_touch = l;
    for (int i = 0; i < WAYS; i++) begin
      if (i == int'(w)) begin
        lru_touch[i*LRU_W +: LRU_W] = '0;
      end else if (l[i*LRU_W +: LRU_W] < lw) begin
        lru_touch[i*LRU_W +: LRU_W] = l[i*LRU_W +: LRU_W] + LRU_W'(1);
      end
    end
  endfunction

  // =====================================================================
  // lookup: the live request in LOOK, otherwise the queued one
  logic [ADDR_W-1:0] lk_addr;
  logic [SET_W-1:0] lk_set;
  logic [SEC_W-1:0] lk_sec;
  logic match;
  logic [WAY_W-1:0] match_way;
  logic sec_ok;
  logic [WAY_W-1:0] vict_way;
  logic vict_evict;
  logic in_fill;
  logic pend_hit;
  logic serve;
  logic sect_done;
  logic fwd_hit;
  logic abort;
  logic line_done;
  logic [SEC_W-1:0] nxt_sec;
  logic [WAY_W-1:0] touch_way;
  logic [SET_W-1:0] cur_set;

  always_comb begin
    lk_addr = (state_r == FFC_LOOK) ? cur_addr_r : pend_addr_r;
    lk_set = lk_addr[SET_LSB +: SET_W];
    lk_sec = lk_addr[SEC_LSB +: SEC_W];
    match = 1'b0;
    match_way = '0;
    for (int i = 0; i < WAYS; i++) begin
      if (alloc_r[lk_set][i] && tag_r[lk_set][i] == lk_addr[TAG_LSB +: TAG_W]) begin
        match = 1'b1;
        match_way = WAY_W'(i);
      end
    end
    sec_ok = match && secv_r[lk_set][match_way][lk_sec];
  end

  ffc_victim u_victim (
    .i_alloc(alloc_r[lk_set]),
    .i_lfu(lfu_r[lk_set]),
    .i_lru(lru_r[lk_set]),
    .o_way(vict_way),
    .o_evict(vict_evict)
  );

  assign cur_set = cur_addr_r[SET_LSB +: SET_W];
  assign in_fill = (state_r == FFC_REQ) || (state_r == FFC_WAIT);
  assign pend_hit = in_fill && pend_v_r && sec_ok;
  assign serve = ((state_r == FFC_LOOK) && sec_ok) || pend_hit;
  assign sect_done = (state_r == FFC_WAIT) && i_fl_valid && (&word_cnt_r);
  assign fwd_hit = (state_r == FFC_WAIT) && i_fl_valid && fwd_pend_r &&
                   cur_sec_r == cur_addr_r[SEC_LSB +: SEC_W] &&
                   word_cnt_r == cur_addr_r[WORD_LSB +: WORD_W];
  // a queued access that the cache cannot serve needs flash
  assign abort = pend_v_r && !pend_hit && !i_full_line;
  assign nxt_sec = cur_sec_r + SEC_W'(1);
  assign line_done = (nxt_sec == start_sec_r);
  assign touch_way = match ? match_way : vict_way;
  // while the target word is outstanding nothing new is taken
  // idle with a queued access must look that one up first, so nothing is taken then
  assign o_cpu_ready = !pend_v_r && ((state_r == FFC_IDLE) || (in_fill && !fwd_pend_r));

  // =====================================================================
  // fill sequencing
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_r <= FFC_IDLE;
      cur_addr_r <= '0;
      pend_addr_r <= '0;
      pend_v_r <= 1'b0;
      fwd_pend_r <= 1'b0;
      way_r <= '0;
      start_sec_r <= '0;
      cur_sec_r <= '0;
      word_cnt_r <= '0;
      o_fl_req <= 1'b0;
      o_fl_addr <= '0;
    end else begin
      o_fl_req <= 1'b0;
      if (in_fill && o_cpu_ready && i_cpu_req && !i_cpu_write) begin
        pend_v_r <= 1'b1;
        pend_addr_r <= i_cpu_addr;
      end
      if (pend_hit) begin
        pend_v_r <= 1'b0;
      end
      if (fwd_hit) begin
        fwd_pend_r <= 1'b0;
      end
      if (state_r == FFC_WAIT && i_fl_valid) begin
        word_cnt_r <= word_cnt_r + WORD_W'(1);
      end
      case (state_r)
        FFC_IDLE: begin
          if (pend_v_r) begin
            // taken on the edge the fill ended, so it still needs its lookup
            cur_addr_r <= pend_addr_r;
            pend_v_r <= 1'b0;
            state_r <= FFC_LOOK;
          end else if (i_cpu_req && !i_cpu_write) begin
            cur_addr_r <= i_cpu_addr;
            state_r <= FFC_LOOK;
          end
        end
        FFC_LOOK: begin
          if (sec_ok) begin
            state_r <= FFC_IDLE;
          end else begin
            // hit/fill keeps its way, a miss takes the victim
            way_r <= touch_way;
            start_sec_r <= i_full_line ? '0 : lk_sec;
            cur_sec_r <= i_full_line ? '0 : lk_sec;
            fwd_pend_r <= 1'b1;
            state_r <= FFC_REQ;
          end
        end
        FFC_REQ: begin
          if (abort) begin
            cur_addr_r <= pend_addr_r;
            pend_v_r <= 1'b0;
            state_r <= FFC_LOOK;
          end else if (secv_r[cur_set][way_r][cur_sec_r]) begin
            if (line_done && pend_v_r && !pend_hit) begin
              cur_addr_r <= pend_addr_r;
              pend_v_r <= 1'b0;
              state_r <= FFC_LOOK;
            end else if (line_done) begin
              // an access taken on this edge stays queued for idle to pick up
              state_r <= FFC_IDLE;
            end else begin
              cur_sec_r <= nxt_sec;
            end
          end else begin
            o_fl_req <= 1'b1;
            o_fl_addr <= {cur_addr_r[ADDR_W-1:SEC_LSB+SEC_W], cur_sec_r,
                          (SEC_LSB)'(0)};
            word_cnt_r <= '0;
            state_r <= FFC_WAIT;
          end
        end
        FFC_WAIT: begin
          if (sect_done) begin
            if (abort || (line_done && pend_v_r && !pend_hit)) begin
              cur_addr_r <= pend_addr_r;
              pend_v_r <= 1'b0;
              state_r <= FFC_LOOK;
            end else if (line_done) begin
              state_r <= FFC_IDLE;
            end else begin
              cur_sec_r <= nxt_sec;
              state_r <= FFC_REQ;
            end
          end
        end
        default: begin
          state_r <= FFC_IDLE;
        end
      endcase
    end
  end

  // =====================================================================
  // tags and section valid flags
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      for (int s = 0; s < SETS; s++) begin
        alloc_r[s] <= '0;
        for (int w = 0; w < WAYS; w++) begin
          tag_r[s][w] <= '0;
          secv_r[s][w] <= '0;
        end
      end
    end else if (state_r == FFC_LOOK && !match) begin
      alloc_r[lk_set][vict_way] <= 1'b1;
      tag_r[lk_set][vict_way] <= lk_addr[TAG_LSB +: TAG_W];
      secv_r[lk_set][vict_way] <= '0;
    end else if (sect_done) begin
      // a section becomes valid only once all its words are in
      secv_r[cur_set][way_r][cur_sec_r] <= 1'b1;
    end
  end

  // =====================================================================
  // replacement state
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      for (int s = 0; s < SETS; s++) begin
        lfu_r[s] <= '0;
        for (int w = 0; w < WAYS; w++) begin
          lru_r[s][w*LRU_W +: LRU_W] <= LRU_W'(w);
        end
      end
    end else if (state_r == FFC_LOOK || pend_hit) begin
      lru_r[lk_set] <= lru_touch(lru_r[lk_set], touch_way);
      if (state_r == FFC_LOOK && !match && vict_evict) begin
        // aging a 1-bit count means clearing it
        lfu_r[lk_set] <= WAYS'(1) << touch_way;
      end else begin
        lfu_r[lk_set][touch_way] <= 1'b1;
      end
    end
  end

  // =====================================================================
  // data storage and processor answer
  always_ff @(posedge i_mclk) begin
    if (state_r == FFC_WAIT && i_fl_valid) begin
      mem[{cur_set, way_r, cur_sec_r, word_cnt_r}] <= i_fl_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_cpu_ack <= 1'b0;
      o_cpu_rdata <= '0;
      o_cpu_wr_err <= 1'b0;
    end else begin
      o_cpu_ack <= serve || fwd_hit;
      o_cpu_wr_err <= o_cpu_ready && i_cpu_req && i_cpu_write;
      if (fwd_hit) begin
        o_cpu_rdata <= i_fl_data;
      end else if (serve) begin
        o_cpu_rdata <= mem[mem_idx(lk_addr, match_way)];
      end
    end
  end

  // =====================================================================
  // checks
  AST_HIT_SERVED: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_r == FFC_LOOK && sec_ok) |=> (o_cpu_ack && !o_fl_req && state_r == FFC_IDLE))
    else $error("hit not served from storage");
  AST_MISS_FILL: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_r == FFC_LOOK && !match) |=> (state_r == FFC_REQ) ##1 o_fl_req)
    else $error("miss did not start a fill");
  AST_CRIT_FIRST: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_r == FFC_LOOK && !sec_ok && !i_full_line)
      |=> ##1 (o_fl_req && o_fl_addr[SEC_LSB +: SEC_W] == $past(lk_sec, 2)))
    else $error("fill did not begin at target section");
  AST_FULL_LINE: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_r == FFC_LOOK && !sec_ok && i_full_line) |=> (cur_sec_r == '0))
    else $error("full-line fill not started at section zero");
  AST_FORWARD: assert property (@(posedge i_mclk) disable iff (i_reset)
    fwd_hit |=> (o_cpu_ack && o_cpu_rdata == $past(i_fl_data)))
    else $error("arriving target word not forwarded");
  AST_ABORT: assert property (@(posedge i_mclk) disable iff (i_reset)
    (sect_done && abort) |=> (state_r == FFC_LOOK && !pend_v_r))
    else $error("fill not aborted for waiting access");
  AST_BOUNDARY: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_r == FFC_WAIT ##1 state_r == FFC_LOOK) |-> $past(sect_done))
    else $error("fill left mid-section");
  AST_WRITE_REFUSED: assert property (@(posedge i_mclk) disable iff (i_reset)
    (o_cpu_ready && i_cpu_req && i_cpu_write && state_r == FFC_IDLE)
      |=> (o_cpu_wr_err && state_r == FFC_IDLE))
    else $error("write was not refused");
  AST_EMPTY_FIRST: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_r == FFC_LOOK && !match && !(&alloc_r[lk_set])) |-> !vict_evict)
    else $error("eviction while an empty way exists");
  AST_AGING: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_r == FFC_LOOK && !match && vict_evict) |=> ($countones(lfu_r[$past(lk_set)]) == 1))
    else $error("use counts not aged on eviction");
  AST_LFU_PREF: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_r == FFC_LOOK && !match && vict_evict && !(&lfu_r[lk_set]))
      |-> !lfu_r[lk_set][vict_way])
    else $error("used line evicted before an unused one");
  AST_RECENT: assert property (@(posedge i_mclk) disable iff (i_reset)
    serve |=> (lru_r[$past(lk_set)][$past(match_way)*LRU_W +: LRU_W] == '0))
    else $error("hit line not made most recent");
  AST_PEND_KEPT: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_r == FFC_IDLE && pend_v_r)
      |=> (state_r == FFC_LOOK && cur_addr_r == $past(pend_addr_r)))
    else $error("queued access dropped at fill end");
endmodule // ffc_cache

// File: logic/ffc_pkg.sv
// Purpose: shared geometry, field positions and states of the flash read cache
// Assumes: 32-bit words, byte addresses into a 32 MB cacheable flash space
// Notes: every width below except LRU_W follows from the geometry constants
package ffc_pkg;
  // =====================================================================
  // geometry
  localparam int ADDR_W = 25;                 // 32 MB of cacheable flash
  localparam int DATA_W = 32;
  localparam int WORD_BYTES = 4;
  localparam int CACHE_BYTES = 32768;         // 32KB of storage
  localparam int WAYS = 4;
  localparam int LINE_BYTES = 512;
  localparam int SECT_BYTES = 64;
  localparam int SECTS = LINE_BYTES / SECT_BYTES;
  localparam int SETS = CACHE_BYTES / (LINE_BYTES * WAYS);
  localparam int SECT_WORDS = SECT_BYTES / WORD_BYTES;
  // =====================================================================
  // field positions
  localparam int WORD_LSB = $clog2(WORD_BYTES);
  localparam int WORD_W = $clog2(SECT_WORDS);
  localparam int SEC_LSB = WORD_LSB + WORD_W;
  localparam int SEC_W = $clog2(SECTS);
  localparam int SET_LSB = SEC_LSB + SEC_W;
  localparam int SET_W = $clog2(SETS);
  localparam int TAG_LSB = SET_LSB + SET_W;
  localparam int TAG_W = ADDR_W - TAG_LSB;
  localparam int WAY_W = $clog2(WAYS);
  localparam int LRU_W = 2;                   // recency value per line
  localparam int MEM_W = SET_W + WAY_W + SEC_W + WORD_W;
  localparam int MEM_WORDS = CACHE_BYTES / WORD_BYTES;
  // =====================================================================
  // controller states, gray along idle-look-request-wait
  typedef enum logic [1:0] {
    FFC_IDLE = 2'b00,
    FFC_LOOK = 2'b01,
    FFC_REQ = 2'b11,
    FFC_WAIT = 2'b10
  } ffc_state_type;
endpackage

// File: logic/ffc_victim.sv
// Purpose: choose the way to fill on a miss
// Assumes: recency values in a set are distinct, 0 is most recent
// Notes: purely combinational
`timescale 1ns/1ps
module ffc_victim (
  input wire logic [ffc_pkg::WAYS-1:0] i_alloc,
  input wire logic [ffc_pkg::WAYS-1:0] i_lfu,
  input wire logic [ffc_pkg::WAYS*ffc_pkg::LRU_W-1:0] i_lru,
  output logic [ffc_pkg::WAY_W-1:0] o_way,
  output logic o_evict
);
  import ffc_pkg::*;
  logic [LRU_W:0] score;
  logic [LRU_W:0] best;
  always_comb begin
    o_way = '0;
    o_evict = 1'b1;
    best = '0;
    score = '0;
    // an empty line is always taken before anything is evicted
    for (int i = WAYS - 1; i >= 0; i--) begin
      if (!i_alloc[i]) begin
        o_way = WAY_W'(i);
        o_evict = 1'b0;
      end
    end
    if (o_evict) begin
      // unused lines outrank used ones, then the least recent wins
      for (int i = 0; i < WAYS; i++) begin
        score = {~i_lfu[i], i_lru[i*LRU_W +: LRU_W]};
        if (i == 0 || score > best) begin
          best = score;
          o_way = WAY_W'(i);
        end
      end
    end
  end
endmodule // ffc_victim

// File: tb/ffc_flash_model.sv
// Purpose: flash side model answering section requests with word bursts
// Assumes: each word value is a fixed function of its byte address
// Notes: the data line toggles between bursts so a stale word never passes for a fresh one
`timescale 1ns/1ps
module ffc_flash_model (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_fl_req,
  input wire logic [ffc_pkg::ADDR_W-1:0] i_fl_addr,
  input wire logic [3:0] i_gap,
  output logic o_fl_valid,
  output logic [ffc_pkg::DATA_W-1:0] o_fl_data,
  output logic o_busy
);
  import ffc_pkg::*;
  logic [ADDR_W-1:0] addr_r;
  int left;
  int idle;
  initial begin
    o_fl_valid = 1'b0;
    o_fl_data = '0;
    o_busy = 1'b0;
    left = 0;
    idle = 0;
  end
  // =====================================================================
  // burst engine: 16 words per request, i_gap idle cycles before each word
  always @(negedge i_mclk) begin
    o_fl_valid <= 1'b0;
    o_fl_data <= ~o_fl_data;
    if (i_reset) begin
      left = 0;
      o_busy <= 1'b0;
    end else if (i_fl_req === 1'b1) begin
      addr_r = i_fl_addr;
      left = 16;
      idle = i_gap;
      o_busy <= 1'b1;
    end else if (left > 0 && idle > 0) begin
      idle--;
    end else if (left > 0) begin
      o_fl_valid <= 1'b1;
      o_fl_data <= 32'h5a00_0000 ^ {7'h0, addr_r};
      addr_r = addr_r + 25'h4;
      left--;
      idle = i_gap;
      o_busy <= (left != 0);
    end
  end
endmodule // ffc_flash_model

// File: tb/ffc_cache_tb.sv
// Purpose: self-checking bench for the flash read cache
// Assumes: flash words come from ffc_flash_model, value derived from address
// Notes: inputs change at the falling edge; every wait is bounded
`timescale 1ns/1ps
module ffc_cache_tb;
  import ffc_pkg::*;
  logic mclk, rst, full_line, cpu_req, cpu_write, cpu_ready, cpu_ack, wr_err;
  logic fl_req, fl_valid, fl_busy;
  logic [ADDR_W-1:0] cpu_addr, fl_addr;
  logic [DATA_W-1:0] rdata, fl_data;
  logic [3:0] gap;
  logic [ADDR_W-1:0] fl_q[$];
  int n_fail;
  int n_tests;

  ffc_cache i_ffc_cache (.i_mclk(mclk), .i_reset(rst), .i_full_line(full_line),
    .i_cpu_req(cpu_req), .i_cpu_write(cpu_write), .i_cpu_addr(cpu_addr),
    .o_cpu_ready(cpu_ready), .o_cpu_ack(cpu_ack), .o_cpu_rdata(rdata), .o_cpu_wr_err(wr_err),
    .o_fl_req(fl_req), .o_fl_addr(fl_addr), .i_fl_valid(fl_valid), .i_fl_data(fl_data));
  ffc_flash_model i_ffc_flash_model (.i_mclk(mclk), .i_reset(rst), .i_fl_req(fl_req),
    .i_fl_addr(fl_addr), .i_gap(gap), .o_fl_valid(fl_valid), .o_fl_data(fl_data),
    .o_busy(fl_busy));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // log every section request; sampled before the edge's updates land
  always @(posedge mclk) if (fl_req === 1'b1) fl_q.push_back(fl_addr);

  // =====================================================================
  // helpers
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bail(input string nm);
    n_fail++;
    $display("ERROR %s expected done seen timeout", nm);
    tally_and_finish();
  endtask
  function automatic logic [ADDR_W-1:0] mk(input int tag, input int set, input int sec,
                                           input int word);
    return {tag[11:0], set[3:0], sec[2:0], word[3:0], 2'b00};
  endfunction
  task automatic wait_ready;
    int k;
    k = 0;
    while (cpu_ready !== 1'b1) begin
      @(negedge mclk);
      if (++k > 3000) bail("ready");
    end
  endtask
  // one read; miss expects the fill to open at section s0, hit expects idle timing
  task automatic rd(input logic [ADDR_W-1:0] a, input bit miss, input int s0);
    int k;
    fl_q.delete();
    @(negedge mclk);
    cpu_req = 1'b1;
    cpu_addr = a;
    wait_ready();
    @(negedge mclk);
    cpu_req = 1'b0;
    k = 0;
    while (cpu_ack !== 1'b1) begin
      @(negedge mclk);
      if (++k > 3000) bail("ack");
    end
    check("rdata", 32'h5a00_0000 ^ {7'h0, a}, rdata);
    if (miss) begin
      check("first section", 32'({a[24:9], s0[2:0], 6'h0}), 32'(fl_q[0]));
      check("forwarded early", 1, 32'(fl_q.size() < 8));
    end else begin
      check("hit latency", 1, k);
      check("hit no flash", 0, 32'(fl_q.size()));
    end
  endtask
  task automatic settle;
    int k;
    int n;
    k = 0;
    n = 0;
    while (n < 5) begin
      @(negedge mclk);
      n = (cpu_ready === 1'b1 && fl_busy === 1'b0 && fl_req !== 1'b1) ? n + 1 : 0;
      if (++k > 5000) bail("settle");
    end
  endtask
  task automatic order(input logic [ADDR_W-1:0] a, input int s0);
    check("fill count", 8, 32'(fl_q.size()));
    foreach (fl_q[i]) check("fill order", 32'({a[24:9], 3'(s0 + i), 6'h0}), 32'(fl_q[i]));
  endtask

  // =====================================================================
  // scenarios
  task automatic t_reset;
    check("ready", 1, 32'(cpu_ready));
    check("ack", 0, 32'(cpu_ack));
    check("fl_req", 0, 32'(fl_req));
    check("rdata", 0, rdata);
    check("fl_addr", 0, 32'(fl_addr));
  endtask
  task automatic t_miss_hit;
    rd(mk(1, 1, 5, 3), 1, 5);
    settle();
    order(mk(1, 1, 5, 3), 5);
    rd(mk(1, 1, 2, 9), 0, 0);
  endtask
  task automatic t_write;
    fl_q.delete();
    @(negedge mclk);
    cpu_req = 1'b1;
    cpu_write = 1'b1;
    cpu_addr = mk(1, 1, 0, 0);
    wait_ready();
    @(negedge mclk);
    cpu_req = 1'b0;
    cpu_write = 1'b0;
    check("wr_err pulse", 1, 32'(wr_err));
    check("no ack on write", 0, 32'(cpu_ack));
    @(negedge mclk);
    check("wr_err width", 0, 32'(wr_err));
    check("write no flash", 0, 32'(fl_q.size()));
    rd(mk(1, 1, 0, 0), 0, 0);
  endtask
  task automatic t_abort;
    gap = 4'h2;
    rd(mk(2, 2, 2, 0), 1, 2);
    rd(mk(3, 3, 0, 0), 1, 0);
    settle();
    order(mk(3, 3, 0, 0), 0);
    gap = 4'h0;
    rd(mk(2, 2, 2, 15), 0, 0);
    rd(mk(2, 2, 4, 1), 1, 4);
    settle();
    check("refill skips valid", 7, 32'(fl_q.size()));
    check("refill last", 32'(mk(2, 2, 3, 0)), 32'(fl_q[6]));
  endtask
  task automatic t_full;
    full_line = 1'b1;
    rd(mk(4095, 15, 6, 1), 1, 0);
    settle();
    order(mk(4095, 15, 6, 1), 0);
    full_line = 1'b0;
  endtask
  task automatic t_evict;
    for (int t = 1; t <= 4; t++) begin
      rd(mk(t, 7, 0, 0), 1, 0);
      settle();
    end
    rd(mk(1, 7, 0, 1), 0, 0);
    rd(mk(5, 7, 0, 0), 1, 0);
    settle();
    rd(mk(1, 7, 0, 2), 0, 0);
    rd(mk(3, 7, 0, 2), 0, 0);
    rd(mk(4, 7, 0, 2), 0, 0);
    rd(mk(2, 7, 0, 2), 1, 0);
    settle();
  endtask

  initial begin
    rst = 1'b1;
    full_line = 1'b0;
    cpu_req = 1'b0;
    cpu_write = 1'b0;
    cpu_addr = '0;
    gap = 4'h0;
    n_fail = 0;
    n_tests = 0;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_miss_hit();
    t_write();
    t_abort();
    t_full();
    t_evict();
    tally_and_finish();
  end
endmodule // ffc_cache_tb
